// ---- logic/mdio_clause22_slave.sv ----
// Clause 22 management slave: frame decode on the link clock, register file on clk_sys
//
// Function
// (RQ1) Master drives management clock up to 12.5MHz; data line is shared half-duplex. The bench station_model runs at about 33 MHz.
// (RQ2) Frame: 32 ones, start 01, opcode, addresses, turnaround, 16 data bits, idle.
// (RQ3) Address and data fields travel most significant bit first.
// (RQ4) Frames without preamble are accepted, shortening transactions from 65 to 33 clocks.
// (RQ5) Master sends at least 32 ones before the first frame after reset.
// (RQ6) Without preamble, start zero is seen right after one idle high clock.
// (RQ7) Act only when frame PHY address equals own address; otherwise leave line undriven.
// (RQ8) Own address latched from five strap pins during hardware reset; the code latches them on the first clk_sys edge after reset release.
// (RQ9) Bad start or opcode: ignore traffic until 32 consecutive ones seen.
// (RQ10) Master sends full preamble after talking to clause 45 devices.
// (RQ11) Always answers as a PHY and holds a subset of clause 22 registers.
// (RQ12) Reduced-strap mode forces PHY address 0x04.
// (RQ13) Page-select register is readable and writable on every page.
// (RQ14) Sample on rising clock; drive only second turnaround and read data.
// (RQ15) Write lands only after all 16 data bits of a matched valid frame.
`timescale 1ns/1ns
`default_nettype none
`include "mgmt_cfg.svh"
module mdio_clause22_slave #(
    parameter int ADDR_W = 5,
    parameter int DATA_W = 16
) (
    input  wire logic              clk_sys,
    input  wire logic              rst_n,
    input  wire logic              mdc_clk,
    input  wire logic              mdio_in,
    output logic                   mdio_out,
    output logic                   mdio_oe,
    input  wire logic [ADDR_W-1:0] addr_strap,
    input  wire logic              reduced_strap,
    input  wire logic [15:0]       partner_ability,
    input  wire logic [15:0]       autoneg_expansion,
    input  wire logic [15:0]       extended_status,
    input  wire logic              irq_summary,
    output logic [15:0]            page_select,
    output logic [15:0]            local_advertisement,
    output logic [15:0]            ctrl_value,
    output logic [ADDR_W-1:0]      phy_addr
);
    initial
    begin
        if (ADDR_W != 5 || DATA_W != 16)
            $error("Clause 22 frames need 5-bit addresses and 16-bit data");
    end

    ////////////////////////////////////////////////////////////////////////////
    // Strap capture on clk_sys; the strap is held while reset is low, so the
    // first edges after release still see it, and the latch is then frozen
    logic              strap_done_q, strap_done_d;
    logic [ADDR_W-1:0] phy_addr_q, phy_addr_d;
    always_comb
    begin
        strap_done_d = 1'b1;
        phy_addr_d   = phy_addr_q;
        if (!strap_done_q)
            phy_addr_d = reduced_strap ? `REDUCED_ADDR : addr_strap; // RQ8 RQ12
    end
    always_ff @(posedge clk_sys or negedge rst_n)
    begin
        if (!rst_n)
        begin
            strap_done_q <= 1'b0;
            phy_addr_q   <= '0;
        end
        else
        begin
            strap_done_q <= strap_done_d;
            phy_addr_q   <= phy_addr_d;
        end
    end
    assign phy_addr = phy_addr_q;

    ////////////////////////////////////////////////////////////////////////////
    // Reset into link domain; the address is used there directly (quasi-static)
    logic       lrst_s1_q, lrst_n;
    always_ff @(posedge mdc_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            lrst_s1_q <= 1'b0;
            lrst_n    <= 1'b0;
        end
        else
        begin
            lrst_s1_q <= 1'b1;
            lrst_n    <= lrst_s1_q;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Frame decoder on the management clock
    mgmt_pkg::frame_state_t st_q, st_d;
    logic [5:0]  ones_q, ones_d;
    logic [4:0]  cnt_q, cnt_d;
    logic [13:0] hdr_q, hdr_d;
    logic [15:0] sh_q, sh_d;
    logic        match_q, match_d;
    logic        rd_q, rd_d;
    logic        oe_q, oe_d;
    logic        out_q, out_d;
    logic        wtog_q, wtog_d;
    logic [4:0]  wreg_q, wreg_d;
    logic [15:0] wdat_q, wdat_d;
    logic [15:0] rdata_l;
    logic [13:0] hdr_n;
    always_comb
    begin
        st_d    = st_q;
        ones_d  = mdio_in ? ((ones_q == `PRE_ONES) ? ones_q : ones_q + 6'd1) : 6'd0;
        cnt_d   = cnt_q + 5'd1;
        hdr_n   = {hdr_q[12:0], mdio_in}; // RQ3
        hdr_d   = hdr_q;
        sh_d    = sh_q;
        match_d = match_q;
        rd_d    = rd_q;
        oe_d    = 1'b0;
        out_d   = 1'b0;
        wtog_d  = wtog_q;
        wreg_d  = wreg_q;
        wdat_d  = wdat_q;
        case (st_q)
            mgmt_pkg::ST_HUNT, mgmt_pkg::ST_LOCK:
                if (ones_d == `PRE_ONES) // RQ5 RQ9
                    st_d = mgmt_pkg::ST_IDLE;
            mgmt_pkg::ST_IDLE:
                if (!mdio_in) // RQ4 RQ6
                begin
                    st_d  = mgmt_pkg::ST_HEAD;
                    hdr_d = 14'h0000;
                    cnt_d = 5'd0;
                end
            mgmt_pkg::ST_HEAD:
            begin
                hdr_d = hdr_n;
                if (cnt_q == 5'd12) // RQ2
                begin
                    // hdr_n = 1 start bit, opcode, phy addr, reg addr
                    if (hdr_n[12] != 1'b1 ||
                        (hdr_n[11:10] != `OP_READ && hdr_n[11:10] != `OP_WRITE))
                        st_d = mgmt_pkg::ST_LOCK; // RQ9
                    else
                    begin
                        st_d    = mgmt_pkg::ST_TA;
                        match_d = (hdr_n[9:5] == phy_addr_q); // RQ7
                        rd_d    = (hdr_n[11:10] == `OP_READ);
                        wreg_d  = hdr_n[4:0];
                        cnt_d   = 5'd0;
                        oe_d    = 1'b0;
                    end
                end
            end
            mgmt_pkg::ST_TA:
            begin
                // Second turnaround bit: drive zero for a matched read
                oe_d  = rd_q && match_q; // RQ14
                cnt_d = 5'd0;
                sh_d  = rdata_l;
                st_d  = rd_q ? mgmt_pkg::ST_RDAT : mgmt_pkg::ST_WDAT;
            end
            mgmt_pkg::ST_RDAT:
            begin
                // The last bit must stand until the edge that samples it; releasing
                // one edge early would hand the master the pull-up level instead
                if (cnt_q == 5'd16)
                    st_d = mgmt_pkg::ST_IDLE;
                else
                begin
                    oe_d  = match_q; // RQ7 RQ14
                    out_d = sh_q[15]; // RQ3
                    sh_d  = {sh_q[14:0], 1'b0};
                end
            end
            mgmt_pkg::ST_WDAT:
            begin
                sh_d = {sh_q[14:0], mdio_in};
                if (cnt_q == 5'd16)
                begin
                    st_d = mgmt_pkg::ST_IDLE;
                    if (match_q) // RQ15
                    begin
                        wdat_d = sh_d; // Includes the last data bit sampled on this edge
                        wtog_d = ~wtog_q;
                    end
                end
            end
            default: st_d = mgmt_pkg::ST_HUNT;
        endcase
    end
    always_ff @(posedge mdc_clk or negedge lrst_n)
    begin
        if (!lrst_n)
        begin
            st_q    <= mgmt_pkg::ST_HUNT;
            ones_q  <= 6'd0;
            cnt_q   <= 5'd0;
            hdr_q   <= 14'h0000;
            sh_q    <= 16'h0000;
            match_q <= 1'b0;
            rd_q    <= 1'b0;
            oe_q    <= 1'b0;
            out_q   <= 1'b0;
            wtog_q  <= 1'b0;
            wreg_q  <= 5'h00;
            wdat_q  <= 16'h0000;
        end
        else
        begin
            st_q    <= st_d;
            ones_q  <= ones_d;
            cnt_q   <= cnt_d;
            hdr_q   <= hdr_d;
            sh_q    <= sh_d;
            match_q <= match_d;
            rd_q    <= rd_d;
            oe_q    <= oe_d;
            out_q   <= out_d;
            wtog_q  <= wtog_d;
            wreg_q  <= wreg_d;
            wdat_q  <= wdat_d;
        end
    end
    assign mdio_oe  = oe_q;
    assign mdio_out = out_q;

    ////////////////////////////////////////////////////////////////////////////
    // Register file on clk_sys; write event crosses as a toggle with the word
    // held stable until the next frame, far longer than the synchroniser delay
    logic        wt_s1_q, wt_s2_q, wt_s3_q;
    logic [15:0] page_q, page_d, adv_q, adv_d, ctrl_q, ctrl_d;
    logic        wr_ev;
    assign wr_ev = wt_s2_q ^ wt_s3_q;
    always_comb
    begin
        page_d = page_q;
        adv_d  = adv_q;
        ctrl_d = ctrl_q;
        if (wr_ev)
            case (wreg_q)
                `REG_PAGE_SEL:  page_d = wdat_q; // RQ13
                `REG_LOCAL_ADV: adv_d  = wdat_q;
                `REG_CTRL:      ctrl_d = wdat_q;
                default:        page_d = page_q;
            endcase
    end
    always_ff @(posedge clk_sys or negedge rst_n)
    begin
        if (!rst_n)
        begin
            wt_s1_q <= 1'b0;
            wt_s2_q <= 1'b0;
            wt_s3_q <= 1'b0;
            page_q  <= `RST_PAGE_SEL;
            adv_q   <= `RST_LOCAL_ADV;
            ctrl_q  <= `RST_CTRL;
        end
        else
        begin
            wt_s1_q <= wtog_q;
            wt_s2_q <= wt_s1_q;
            wt_s3_q <= wt_s2_q;
            page_q  <= page_d;
            adv_q   <= adv_d;
            ctrl_q  <= ctrl_d;
        end
    end
    assign page_select         = page_q;
    assign local_advertisement = adv_q;
    assign ctrl_value          = ctrl_q;

    ////////////////////////////////////////////////////////////////////////////
    // Read mux: sampled at turnaround; the writable registers change only on management
    // writes, so they are quiet during a read frame
    always_comb
    begin
        case (wreg_q)
            `REG_CTRL:       rdata_l = ctrl_q; // RQ11
            `REG_STATUS:     rdata_l = `RST_STATUS;
            `REG_ID1:        rdata_l = `ID1_VALUE; // Arbitrary identity value
            `REG_ID2:        rdata_l = `ID2_VALUE; // Arbitrary identity value
            `REG_LOCAL_ADV:  rdata_l = adv_q;
            `REG_PARTNER:    rdata_l = partner_ability;
            `REG_AUTONEG_EXPANSION:     rdata_l = autoneg_expansion;
            `REG_EXT_STATUS: rdata_l = extended_status;
            `REG_PAGE_SEL:   rdata_l = {irq_summary, page_q[14:0]}; // RQ13
            default:         rdata_l = 16'h0000;
        endcase
    end

    ////////////////////////////////////////////////////////////////////////////
    // Checks on the link side, and the strap capture checks on clk_sys
    a_drive_only_read: assert property (@(posedge mdc_clk) disable iff (!lrst_n)
        mdio_oe |-> ($past(st_q) == mgmt_pkg::ST_TA || $past(st_q) == mgmt_pkg::ST_RDAT) && rd_q && match_q)
        else $error("Data line driven outside a matched read"); // RQ14
    a_lock_holds: assert property (@(posedge mdc_clk) disable iff (!lrst_n)
        (st_q == mgmt_pkg::ST_LOCK && ones_q < 6'd31) |=> st_q == mgmt_pkg::ST_LOCK)
        else $error("Left lockout before full preamble"); // RQ9
    a_start_detect: assert property (@(posedge mdc_clk) disable iff (!lrst_n)
        (st_q == mgmt_pkg::ST_IDLE && !mdio_in) |=> st_q == mgmt_pkg::ST_HEAD)
        else $error("Start zero after idle missed"); // RQ6
    a_nomatch_quiet: assert property (@(posedge mdc_clk) disable iff (!lrst_n)
        !match_q |-> !mdio_oe)
        else $error("Unmatched frame drove the line"); // RQ7
    a_ta_zero: assert property (@(posedge mdc_clk) disable iff (!lrst_n)
        (st_q == mgmt_pkg::ST_TA && rd_q && match_q) |=> mdio_oe && !mdio_out)
        else $error("Turnaround zero not driven"); // RQ14
    a_write_late: assert property (@(posedge mdc_clk) disable iff (!lrst_n)
        (wtog_q != $past(wtog_q)) |-> $past(st_q) == mgmt_pkg::ST_WDAT && $past(cnt_q) == 5'd16)
        else $error("Write committed before all data bits"); // RQ15
    a_addr_frozen: assert property (@(posedge clk_sys) disable iff (!rst_n)
        strap_done_q |=> $stable(phy_addr_q))
        else $error("Address changed after capture"); // RQ8
    a_reduced_addr: assert property (@(posedge clk_sys) disable iff (!rst_n)
        (!strap_done_q && reduced_strap) |=> phy_addr_q == `REDUCED_ADDR)
        else $error("Reduced mode address wrong"); // RQ12
endmodule // mdio_clause22_slave
`default_nettype wire

// ---- logic/mgmt_cfg.svh ----
// Constants for the clause 22 management slave: offsets, strap values, frame timing
`ifndef MGMT_CFG_SVH
`define MGMT_CFG_SVH
`define PRE_ONES        6'd32
`define ST_CODE         2'b01
`define OP_READ         2'b10
`define OP_WRITE        2'b01
`define REDUCED_ADDR    5'h04
`define REG_CTRL        5'h00
`define REG_STATUS      5'h01
`define REG_ID1         5'h02
`define REG_ID2         5'h03
`define REG_LOCAL_ADV   5'h04
`define REG_PARTNER     5'h05
`define REG_AUTONEG_EXPANSION      5'h06
`define REG_EXT_STATUS  5'h0f
`define REG_PAGE_SEL    5'h1f
`define RST_CTRL        16'h1140
`define RST_STATUS      16'h0109
`define RST_LOCAL_ADV   16'h0020
`define RST_PAGE_SEL    16'h0000
`define ID1_VALUE       16'h1234
`define ID2_VALUE       16'h5670
`endif

// ---- logic/mgmt_pkg.sv ----
// Types for the clause 22 management slave
`default_nettype none
package mgmt_pkg;
    typedef enum logic [6:0] {
        ST_HUNT = 7'h01,
        ST_IDLE = 7'h02,
        ST_HEAD = 7'h04,
        ST_TA   = 7'h08,
        ST_RDAT = 7'h10,
        ST_WDAT = 7'h20,
        ST_LOCK = 7'h40
    } frame_state_t;
endpackage
`default_nettype wire

// ---- testbench/station_model.sv ----
// Behavioural station manager: drives the management clock and frames onto the shared line
`timescale 1ns/1ns
`default_nettype none
module station_model #(
    parameter int HALF = 15 // 30 ns period, about 33 MHz, above the 12.5 MHz ceiling
) (
    output logic     mdc_clk,
    output logic     drv_out,
    output logic     drv_oe,
    input  wire logic line
);
    initial
    begin
        mdc_clk = 1'b0;
        drv_out = 1'b1;
        drv_oe  = 1'b0;
    end

    ////////////////////////////////////////////////////////////////////////////////
    // One bit period: data changes while the clock is low, both ends sample at the rise
    task automatic put(input logic b, input logic oe, output logic s);
    begin
        mdc_clk = 1'b0;
        drv_out = b;
        drv_oe  = oe; // Released line falls back to the pull-up
        #HALF;
        s = line;
        mdc_clk = 1'b1;
        #HALF;
    end
    endtask

    // Whole frame plus one released idle bit; the clock stands still low afterwards, and a write commits on the last data bit
    task automatic frame(input int pre, input logic [1:0] st, input logic [1:0] op, input logic [4:0] pa,
                         input logic [4:0] ra, input logic [15:0] wd, output logic [15:0] rd, output logic ta2);
        logic [31:0] hdr;
        logic        s;
    begin
        hdr = {st, op, pa, ra, 2'b10, wd};
        repeat (pre) put(1'b1, 1'b1, s);
        for (int i = 31; i >= 0; i--)
        begin
            put(hdr[i], (op != 2'b10) || (i > 17), s);
            if (i == 16)
                ta2 = s;
            if (i < 16)
                rd[i] = s;
        end
        put(1'b1, 1'b0, s);
        mdc_clk = 1'b0;
    end
    endtask
endmodule // station_model
`default_nettype wire

// ---- testbench/testbench.sv ----
// Self-checking bench for the clause 22 management slave
`timescale 1ns/1ns
`default_nettype none
`include "mgmt_cfg.svh"
`define CHK(n, e, g) check(n, e, g)
module testbench;
    logic        clk_sys = 1'b0;
    logic        rst_n;
    logic [4:0]  addr_strap = 5'h13;
    logic        reduced_strap = 1'b0;
    logic [15:0] partner_ability = 16'h41e1;
    logic [15:0] autoneg_expansion = 16'h0006;
    logic [15:0] extended_status = 16'h8000;
    logic        irq_summary = 1'b1;
    logic [15:0] page_select, local_advertisement, ctrl_value, rd;
    logic [4:0]  phy_addr;
    logic        mdc_clk, mdio_out, mdio_oe, drv_out, drv_oe, ta;
    int          fails = 0;
    int          num_checks = 0;
    // Pull-up holds the line high whenever nobody drives it
    wire logic   mdio_line = mdio_oe ? mdio_out : (drv_oe ? drv_out : 1'b1);

    always #5 clk_sys = ~clk_sys;

    mdio_clause22_slave uut (.clk_sys(clk_sys), .rst_n(rst_n), .mdc_clk(mdc_clk), .mdio_in(mdio_line),
        .mdio_out(mdio_out), .mdio_oe(mdio_oe), .addr_strap(addr_strap), .reduced_strap(reduced_strap),
        .partner_ability(partner_ability), .autoneg_expansion(autoneg_expansion),
        .extended_status(extended_status), .irq_summary(irq_summary), .page_select(page_select),
        .local_advertisement(local_advertisement), .ctrl_value(ctrl_value), .phy_addr(phy_addr));
    station_model mgr (.mdc_clk(mdc_clk), .drv_out(drv_out), .drv_oe(drv_oe), .line(mdio_line));

    ////////////////////////////////////////////////////////////////////////////////
    task automatic check(input string n, input logic [15:0] e, input logic [15:0] g);
    begin
        num_checks++;
        if (g !== e)
        begin
            fails++;
            $display("[FAIL] %s expected %h seen %h", n, e, g);
        end
    end
    endtask

    task automatic summarize;
    begin
        $display("checks %0d mismatches %0d", num_checks, fails);
        if (fails == 0 && num_checks > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    end
    endtask

    // Both ends driving at once would short the shared line
    always @(posedge mdc_clk)
        `CHK("contention", 16'h0000, 16'(mdio_oe & drv_oe));

    task automatic rd_reg(input int pre, input logic [4:0] pa, input logic [4:0] ra, input logic [15:0] e,
                          input string n);
    begin
        mgr.frame(pre, `ST_CODE, `OP_READ, pa, ra, 16'h0000, rd, ta);
        `CHK(n, e, rd);
    end
    endtask

    // Commit lands a few system clocks after the last data bit edge, so allow a margin
    task automatic wr_reg(input int pre, input logic [4:0] pa, input logic [4:0] ra, input logic [15:0] d);
    begin
        mgr.frame(pre, `ST_CODE, `OP_WRITE, pa, ra, d, rd, ta);
        repeat (10) @(posedge clk_sys);
    end
    endtask

    task automatic do_reset(input logic [4:0] s, input logic red);
    begin
        @(posedge clk_sys);
        rst_n <= 1'b0;
        addr_strap <= s;
        reduced_strap <= red;
        repeat (3) @(posedge clk_sys);
        rst_n <= 1'b1;
        repeat (3) @(posedge clk_sys);
        addr_strap <= ~s; // Later strap changes must not reach the address
        repeat (3) @(posedge clk_sys);
    end
    endtask

    ////////////////////////////////////////////////////////////////////////////////
    task automatic t_reset;
    begin
        `CHK("ctrl", `RST_CTRL, ctrl_value);
        `CHK("adv", `RST_LOCAL_ADV, local_advertisement);
        `CHK("page", `RST_PAGE_SEL, page_select);
        `CHK("phy_addr", 16'h0013, 16'(phy_addr));
    end
    endtask

    task automatic t_rw;
    begin
        wr_reg(36, 5'h13, `REG_LOCAL_ADV, 16'habcd);
        `CHK("adv out", 16'habcd, local_advertisement);
        rd_reg(0, 5'h13, `REG_LOCAL_ADV, 16'habcd, "adv rd");
        `CHK("turnaround", 16'h0000, 16'(ta));
        wr_reg(0, 5'h13, `REG_CTRL, 16'h0100);
        rd_reg(0, 5'h13, `REG_CTRL, 16'h0100, "ctrl rd");
    end
    endtask

    task automatic t_map;
    begin
        rd_reg(0, 5'h13, `REG_STATUS, `RST_STATUS, "status");
        rd_reg(0, 5'h13, `REG_ID2, `ID2_VALUE, "id2");
        rd_reg(0, 5'h13, `REG_PARTNER, partner_ability, "partner");
        wr_reg(0, 5'h13, `REG_AUTONEG_EXPANSION, 16'hffff);
        rd_reg(0, 5'h13, `REG_AUTONEG_EXPANSION, autoneg_expansion, "expansion");
        rd_reg(0, 5'h13, `REG_EXT_STATUS, extended_status, "ext status");
        rd_reg(0, 5'h13, 5'h07, 16'h0000, "unmapped");
        wr_reg(0, 5'h13, `REG_PAGE_SEL, 16'h0003);
        `CHK("page out", 16'h0003, page_select);
        rd_reg(0, 5'h13, `REG_PAGE_SEL, 16'h8003, "page irq");
        @(posedge clk_sys);
        irq_summary <= 1'b0;
        rd_reg(0, 5'h13, `REG_PAGE_SEL, 16'h0003, "page quiet");
    end
    endtask

    // Foreign address: no write, and the line stays on the pull-up through the read
    task automatic t_match;
    begin
        wr_reg(0, 5'h05, `REG_CTRL, 16'h0000);
        `CHK("ctrl kept", 16'h0100, ctrl_value);
        rd_reg(0, 5'h05, `REG_CTRL, 16'hffff, "foreign rd");
        `CHK("foreign ta", 16'h0001, 16'(ta));
    end
    endtask

    // Bad start or opcode locks the decoder until a full run of ones
    task automatic t_bad;
        logic [3:0] bad [4] = '{4'b0001, 4'b0010, 4'b0100, 4'b0111};
    begin
        for (int i = 0; i < 4; i++)
        begin
            mgr.frame(0, bad[i][3:2], bad[i][1:0], 5'h13, `REG_CTRL, 16'h0000, rd, ta);
            wr_reg(0, 5'h13, `REG_CTRL, 16'h2222);
            rd_reg(32, 5'h13, `REG_CTRL, 16'h0100, "locked");
        end
    end
    endtask

    task automatic t_strap;
    begin
        do_reset(5'h0a, 1'b1);
        `CHK("reduced addr", 16'(`REDUCED_ADDR), 16'(phy_addr));
        rd_reg(36, `REDUCED_ADDR, `REG_CTRL, `RST_CTRL, "reduced rd");
        rd_reg(0, 5'h0a, `REG_CTRL, 16'hffff, "strap ignored");
        do_reset(5'h0a, 1'b0);
        `CHK("strap addr", 16'h000a, 16'(phy_addr));
        rd_reg(36, 5'h0a, `REG_LOCAL_ADV, `RST_LOCAL_ADV, "strap rd");
    end
    endtask

    ////////////////////////////////////////////////////////////////////////////////
    initial
    begin
        rst_n <= 1'b0; // A real falling edge, so the idle link-side flops see reset
        repeat (3) @(posedge clk_sys);
        rst_n <= 1'b1;
        repeat (3) @(posedge clk_sys);
        t_reset;
        t_rw;
        t_map;
        t_match;
        t_bad;
        t_strap;
        summarize;
    end

    // About 30 frames of at most about 2 us; anything far beyond that is a hang
    initial
    begin
        #200000;
        fails++;
        summarize;
    end
endmodule // testbench
`default_nettype wire
